// ===== design/fws_map.vh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * fault and warning supervisor.
 * Assumes it is included by bare name from design files only.
 */
`ifndef FWS_MAP_VH
`define FWS_MAP_VH

// ***************************************************************
// Register offsets
// ***************************************************************
`define FWS_ADDR_MISC1 8'h01
`define FWS_ADDR_MISC3 8'h21
`define FWS_ADDR_CLIPCTL 8'h22
`define FWS_ADDR_CLIPWIN 8'h23
`define FWS_ADDR_ILIM_ST 8'h25
`define FWS_ADDR_FAULT_ST 8'h26
`define FWS_ADDR_CHAN_ST 8'h27
`define FWS_ADDR_WARN_ST 8'h28
`define FWS_ADDR_FAULT_MSK 8'h29
`define FWS_ADDR_WARN_MSK 8'h2a

// ***************************************************************
// Reset values
// ***************************************************************
`define FWS_RST_MISC1 8'h00
`define FWS_RST_MISC3 8'h00
`define FWS_RST_CLIPCTL 8'h00
`define FWS_RST_CLIPWIN 8'h14
`define FWS_RST_MASK 8'h00

// ***************************************************************
// Field positions
// ***************************************************************
`define FWS_M1_ILIM_LVL 4
`define FWS_M1_TWARN_LO 5
`define FWS_M1_TWARN_HI 6
`define FWS_M3_CLEAR 7
`define FWS_M3_AUTOREC 3
`define FWS_CC_NONLATCH 0
`define FWS_FS_BAT_UNDER 0
`define FWS_FS_STG_UNDER 1
`define FWS_FS_OVER 2
`define FWS_FS_CLK 3
`define FWS_FS_TSHUT 4
`define FWS_WS_POR 0
`define FWS_WS_CLIP 1
`define FWS_WS_TWARN 2
`define FWS_WS_ILIM 3
`define FWS_FM_VOLT 0
`define FWS_FM_CLK 1
`define FWS_FM_TSHUT 2
`define FWS_FM_OVERCUR 3
`define FWS_FM_DC 4
`define FWS_WM_CLIP 0
`define FWS_WM_TWARN 1
`define FWS_WM_ILIM 2

// ***************************************************************
// Timing
// ***************************************************************
`define FWS_CLK_MHZ 100
`define FWS_RAMP_MS 5
`define FWS_RAMP_CYCLES (`FWS_RAMP_MS * 1000 * `FWS_CLK_MHZ)
`define FWS_STBY_HOLD_MS 15

`endif

// ===== design/fws_clip_det.v
/*
 * Clip run detector for one channel: counts consecutive PWM clocks spent at
 * full modulation and flags once the run reaches the programmed window.
 * Assumes i_pwm_tick is a one-cycle pulse per PWM clock, synchronous to i_clock.
 */
`timescale 1ns/10ps

module fws_clip_det (
  input wire i_clock,
  input wire i_rst,
  input wire i_full_mod,
  input wire i_pwm_tick,
  input wire [7:0] i_window,
  output reg o_clip_run
);

  reg [7:0] run_q;
  reg [7:0] run_d;

  // Run length; saturates so a long clip never wraps back below the window
  always @* begin
    run_d = run_q;
    if (!i_full_mod) begin
      run_d = 8'h00;
    end else if (i_pwm_tick && (run_q != 8'hff)) begin
      run_d = run_q + 8'h01;
    end
  end

  // [RQ11] run reaches window
  always @(posedge i_clock) begin
    if (i_rst) begin
      run_q <= 8'h00;
      o_clip_run <= 1'b0;
    end else begin
      run_q <= run_d;
      o_clip_run <= i_full_mod && (run_d >= i_window);
    end
  end

endmodule

// ===== design/fws_supervisor.v
/*
 * Fault and warning supervisor of a four-channel class-D amplifier: latched
 * status, masked alert pins, mute/standby pins and the operating state.
 * Assumes all event inputs are levels synchronous to i_clock, i_rst is the
 * core power-on reset, and the serial bus front end turns transfers into
 * one-cycle register strobes.
 */
// What this block does
// [RQ1] Undervoltage on either high supply asserts fault alert and sets status.
// [RQ2] Power-on reset restores register defaults and releases the control bus.
// [RQ3] After power-on reset, the reset warning bit and warning alert are set.
// [RQ4] Output stage overvoltage asserts fault alert and sets its status bit.
// [RQ5] Host holds standby low at least 15 ms before removing supplies.
// [RQ6] Fault alert covers channel faults, shutdown, supply faults, clock errors.
// [RQ7] Fault alert stays latched until the clear-fault bit is written.
// [RQ8] Fault status bits stay set until the clear-fault bit is written.
// [RQ9] Fault masks gate only the alert pin; nothing masked after reset.
// [RQ10] Warning alert covers clipping, thermal warning, current limit, reset.
// [RQ11] Clip flagged after a programmable run of full-modulation PWM clocks.
// [RQ12] Latching clip status stays set until the clear-fault bit.
// [RQ13] Thermal warning is global or any channel; threshold in misc control one.
// [RQ14] Clip and thermal warning masks gate only the warning alert pin.
// [RQ15] Warning alert latches until the clear-fault bit is written.
// [RQ16] Mute pin low mutes all channels, high unmutes.
// [RQ17] Standby pin low shuts down, ramping outputs within 5 ms.
// [RQ18] Four states: standby, high impedance, mute, play.
// [RQ19] Reset forces standby; supply faults and shutdown force high impedance.
// [RQ20] In mute/play, overcurrent or DC offset puts that channel in high impedance.
// [RQ21] Non-latching clip follows full modulation directly.
// [RQ22] Clear-fault is a pulse clearing latches whose cause has gone.
`timescale 1ns/10ps
`include "fws_map.vh"

module fws_supervisor #(
  parameter RAMP_CYCLES = `FWS_RAMP_CYCLES
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata,
  output reg o_bus_hiz,
  input wire i_bat_undervoltage_event,
  input wire i_stage_undervoltage_event,
  input wire i_overvoltage_event,
  input wire i_clock_error,
  input wire i_overtemp_shutdown,
  input wire i_overtemp_warning,
  input wire [3:0] i_chan_overtemp_warning,
  input wire [3:0] i_current_limit_warning,
  input wire [3:0] i_chan_overcurrent,
  input wire [3:0] i_chan_dc_offset,
  input wire [3:0] i_chan_full_mod,
  input wire i_pwm_tick,
  input wire i_mute_n,
  input wire i_standby_n,
  output wire o_fault_out,
  output reg o_fault_oe_n,
  output wire o_warn_out,
  output reg o_warn_oe_n,
  output reg [3:0] o_state,
  output reg o_osc_run,
  output reg o_ramp_down,
  output reg [3:0] o_chan_hiz,
  output reg [1:0] o_overtemp_warning_threshold,
  output reg o_current_limit_level
);

  // ***************************************************************
  // States
  // ***************************************************************
  localparam [3:0] ST_STBY = 4'b0001;
  localparam [3:0] ST_HIZ = 4'b0010;
  localparam [3:0] ST_MUTE = 4'b0100;
  localparam [3:0] ST_PLAY = 4'b1000;
  localparam [18:0] RAMP_LAST = RAMP_CYCLES[18:0] - 19'h00001;

  // ***************************************************************
  // Registers
  // ***************************************************************
  reg [7:0] misc1_q;
  reg [7:0] misc3_q;
  reg [7:0] clipctl_q;
  reg [7:0] clipwin_q;
  reg [7:0] fmask_q;
  reg [7:0] wmask_q;
  reg [4:0] fstat_q;
  reg [7:0] chan_q;
  reg [3:0] ilim_q;
  reg [3:0] cotw_q;
  reg por_q;
  reg clip_q;
  reg twarn_q;
  reg fault_lat_q;
  reg warn_lat_q;
  reg tshut_hold_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [18:0] ramp_q;
  reg [18:0] ramp_d;
  wire [3:0] clip_run;
  wire clear;
  wire active;
  wire play_mute;
  wire [4:0] fcond;
  wire [7:0] ccond;
  wire any_clip;
  wire twarn_now;
  wire fault_now;
  wire warn_now;
  wire force_hiz;

  // [RQ22] one-cycle clear pulse
  assign clear = i_reg_wr && (i_reg_addr == `FWS_ADDR_MISC3) &&
                 i_reg_wdata[`FWS_M3_CLEAR];

  // Supply and thermal faults are monitored outside standby only
  assign active = !state_q[0];
  assign play_mute = state_q[2] | state_q[3];

  // ***************************************************************
  // Clip detection, one detector per channel
  // ***************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_clip
      fws_clip_det u_clip (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_full_mod(i_chan_full_mod[ch]),
        .i_pwm_tick(i_pwm_tick),
        .i_window(clipwin_q),
        .o_clip_run(clip_run[ch])
      );
    end
  endgenerate

  // [RQ20] clipping only watched in mute and play
  // [RQ21] non-latching mode follows full modulation
  assign any_clip = play_mute && (clipctl_q[`FWS_CC_NONLATCH] ?
                    (|i_chan_full_mod) : (|clip_run));

  // [RQ13] global or any channel warning
  assign twarn_now = active && (i_overtemp_warning || (|i_chan_overtemp_warning));

  // Live fault conditions in status bit order
  // [RQ1] either supply undervoltage
  // [RQ4] output stage overvoltage
  assign fcond = {i_overtemp_shutdown, i_clock_error, i_overvoltage_event,
                  i_stage_undervoltage_event, i_bat_undervoltage_event} &
                 {5{active}};
  assign ccond = {i_chan_dc_offset, i_chan_overcurrent} & {8{play_mute}};

  // [RQ6] fault categories gated by masks
  // [RQ9] masks reach only the pin
  assign fault_now =
    ((fcond[`FWS_FS_BAT_UNDER] | fcond[`FWS_FS_STG_UNDER] | fcond[`FWS_FS_OVER]) &
     !fmask_q[`FWS_FM_VOLT]) |
    (fcond[`FWS_FS_CLK] & !fmask_q[`FWS_FM_CLK]) |
    (fcond[`FWS_FS_TSHUT] & !fmask_q[`FWS_FM_TSHUT]) |
    ((|ccond[3:0]) & !fmask_q[`FWS_FM_OVERCUR]) |
    ((|ccond[7:4]) & !fmask_q[`FWS_FM_DC]);

  // [RQ10] warning categories
  // [RQ14] clip and thermal masks reach only the pin
  assign warn_now = (any_clip & !wmask_q[`FWS_WM_CLIP]) |
                    (twarn_now & !wmask_q[`FWS_WM_TWARN]) |
                    ((|i_current_limit_warning) & play_mute & !wmask_q[`FWS_WM_ILIM]);

  // [RQ19] supply faults and shutdown force high impedance
  assign force_hiz = (|fcond[2:0]) | tshut_hold_q;

  // ***************************************************************
  // Control registers and latched status
  // ***************************************************************
  // [RQ2] every register back to default on reset
  always @(posedge i_clock) begin
    if (i_rst) begin
      misc1_q <= `FWS_RST_MISC1;
      misc3_q <= `FWS_RST_MISC3;
      clipctl_q <= `FWS_RST_CLIPCTL;
      clipwin_q <= `FWS_RST_CLIPWIN;
      fmask_q <= `FWS_RST_MASK;
      wmask_q <= `FWS_RST_MASK;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `FWS_ADDR_MISC1: misc1_q <= i_reg_wdata;
        // Clear bit is never stored, so it reads back as zero
        `FWS_ADDR_MISC3: misc3_q <= i_reg_wdata & 8'h7f;
        `FWS_ADDR_CLIPCTL: clipctl_q <= i_reg_wdata;
        `FWS_ADDR_CLIPWIN: clipwin_q <= i_reg_wdata;
        `FWS_ADDR_FAULT_MSK: fmask_q <= i_reg_wdata;
        `FWS_ADDR_WARN_MSK: wmask_q <= i_reg_wdata;
        default: misc1_q <= misc1_q;
      endcase
    end
  end

  // Set beats clear everywhere, so an event in the clear cycle is never lost
  always @(posedge i_clock) begin
    if (i_rst) begin
      fstat_q <= 5'h00;
      chan_q <= 8'h00;
      ilim_q <= 4'h0;
      cotw_q <= 4'h0;
      // [RQ3] reset warning set at power-up
      por_q <= 1'b1;
      clip_q <= 1'b0;
      twarn_q <= 1'b0;
      fault_lat_q <= 1'b0;
      warn_lat_q <= 1'b1;
      tshut_hold_q <= 1'b0;
    end else begin
      // [RQ8] sticky fault status
      fstat_q <= fcond | (fstat_q & {5{!clear}});
      chan_q <= ccond | (chan_q & {8{!clear}});
      ilim_q <= (i_current_limit_warning & {4{play_mute}}) | (ilim_q & {4{!clear}});
      cotw_q <= (i_chan_overtemp_warning & {4{active}}) | (cotw_q & {4{!clear}});
      por_q <= por_q & !clear;
      // [RQ12] latching clip status; non-latching follows live
      if (clipctl_q[`FWS_CC_NONLATCH]) begin
        clip_q <= any_clip;
      end else begin
        clip_q <= any_clip | (clip_q & !clear);
      end
      twarn_q <= (active && i_overtemp_warning) | (twarn_q & !clear);
      // [RQ7] fault alert latch
      fault_lat_q <= fault_now | (fault_lat_q & !clear);
      // [RQ15] warning alert latch
      warn_lat_q <= warn_now | (warn_lat_q & !clear);
      // Shutdown holds unless auto-recovery lets it follow temperature
      if (misc3_q[`FWS_M3_AUTOREC]) begin
        tshut_hold_q <= fcond[`FWS_FS_TSHUT];
      end else begin
        tshut_hold_q <= fcond[`FWS_FS_TSHUT] | (tshut_hold_q & !clear);
      end
    end
  end

  // ***************************************************************
  // Operating state
  // ***************************************************************
  // [RQ18] four states with ramp before standby from mute or play
  always @* begin
    state_d = state_q;
    ramp_d = 19'h00000;
    case (state_q)
      ST_STBY: begin
        if (i_standby_n) begin
          state_d = ST_HIZ;
        end
      end
      ST_HIZ: begin
        if (!i_standby_n) begin
          state_d = ST_STBY;
        end else if (!force_hiz) begin
          state_d = i_mute_n ? ST_PLAY : ST_MUTE;
        end
      end
      ST_MUTE, ST_PLAY: begin
        // [RQ17] ramp down before standby
        if (!i_standby_n) begin
          ramp_d = ramp_q + 19'h00001;
          if (ramp_q == RAMP_LAST) begin
            state_d = ST_STBY;
            ramp_d = 19'h00000;
          end
        end else if (force_hiz) begin
          state_d = ST_HIZ;
        end else begin
          // [RQ16] mute pin selects mute or play for all channels
          state_d = i_mute_n ? ST_PLAY : ST_MUTE;
        end
      end
      default: state_d = ST_STBY;
    endcase
  end

  // [RQ19] reset forces standby
  always @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= ST_STBY;
      ramp_q <= 19'h00000;
    end else begin
      state_q <= state_d;
      ramp_q <= ramp_d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // Open-drain pins only ever drive low
  assign o_fault_out = 1'b0;
  assign o_warn_out = 1'b0;

  always @(posedge i_clock) begin
    if (i_rst) begin
      o_fault_oe_n <= 1'b1;
      o_warn_oe_n <= 1'b1;
      o_state <= ST_STBY;
      o_osc_run <= 1'b0;
      o_ramp_down <= 1'b0;
      o_chan_hiz <= 4'hf;
      o_overtemp_warning_threshold <= 2'b00;
      o_current_limit_level <= 1'b0;
      o_bus_hiz <= 1'b1;
    end else begin
      // [RQ6] fault pin follows its latch
      o_fault_oe_n <= !(fault_now | (fault_lat_q & !clear));
      // [RQ10] warning pin follows its latch
      o_warn_oe_n <= !(warn_now | (warn_lat_q & !clear));
      o_state <= state_d;
      o_osc_run <= !state_d[0];
      o_ramp_down <= (state_d[2] | state_d[3]) & !i_standby_n;
      // [RQ20] channel fault holds that channel in high impedance
      o_chan_hiz <= ~{4{state_d[2] | state_d[3]}} |
                    ccond[3:0] | ccond[7:4] | ((chan_q[3:0] | chan_q[7:4]) & {4{!clear}});
      o_overtemp_warning_threshold <= misc1_q[`FWS_M1_TWARN_HI:`FWS_M1_TWARN_LO];
      o_current_limit_level <= misc1_q[`FWS_M1_ILIM_LVL];
      // [RQ2] bus released while in reset
      o_bus_hiz <= 1'b0;
    end
  end

  // Read data registered on the read strobe; unmapped reads as zero
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `FWS_ADDR_MISC1: o_reg_rdata <= misc1_q;
        `FWS_ADDR_MISC3: o_reg_rdata <= misc3_q;
        `FWS_ADDR_CLIPCTL: o_reg_rdata <= clipctl_q;
        `FWS_ADDR_CLIPWIN: o_reg_rdata <= clipwin_q;
        `FWS_ADDR_ILIM_ST: o_reg_rdata <= {4'h0, ilim_q};
        `FWS_ADDR_FAULT_ST: o_reg_rdata <= {3'b000, fstat_q};
        `FWS_ADDR_CHAN_ST: o_reg_rdata <= chan_q;
        `FWS_ADDR_WARN_ST: o_reg_rdata <= {cotw_q, |ilim_q, twarn_q, clip_q, por_q};
        `FWS_ADDR_FAULT_MSK: o_reg_rdata <= fmask_q;
        `FWS_ADDR_WARN_MSK: o_reg_rdata <= wmask_q;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// ===== test/fws_supervisor_properties.sv
/* Port checker for the fault and warning supervisor.
   Assumes it is bound to fws_supervisor, one clock, sync reset. */
`timescale 1ns/10ps
module fws_props #(
  parameter RAMP_CYCLES = 16
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_reg_wr,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire o_bus_hiz,
  input wire i_bat_undervoltage_event,
  input wire i_stage_undervoltage_event,
  input wire i_overvoltage_event,
  input wire i_clock_error,
  input wire i_overtemp_shutdown,
  input wire [3:0] i_chan_overcurrent,
  input wire [3:0] i_chan_dc_offset,
  input wire i_mute_n,
  input wire i_standby_n,
  input wire o_fault_oe_n,
  input wire o_warn_oe_n,
  input wire [3:0] o_state,
  input wire o_osc_run,
  input wire o_ramp_down,
  input wire [3:0] o_chan_hiz
);
  // ********
  // Helpers
  // ********
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // A live cause wins over a clear
  wire live = i_bat_undervoltage_event | i_stage_undervoltage_event |
    i_overvoltage_event | i_clock_error | i_overtemp_shutdown |
    (|i_chan_overcurrent) | (|i_chan_dc_offset);
  wire clr = i_reg_wr & (i_reg_addr == 8'h21) & i_reg_wdata[7];
  // Mask writes may move a pin, so they end a hold
  wire mwr = i_reg_wr & ((i_reg_addr == 8'h29) | (i_reg_addr == 8'h2a));
  wire run = o_state[2] | o_state[3];
  reg [31:0] ramp_q;
  // Ramp length in cycles
  always @(posedge i_clock) begin
    if (i_rst || !o_ramp_down) begin
      ramp_q <= 32'h0;
    end else begin
      ramp_q <= ramp_q + 32'h1;
    end
  end
  sequence s_clear;
    clr ##0 !live;
  endsequence
  sequence s_overvolt_run;
    run && i_standby_n ##0 i_overvoltage_event;
  endsequence
  // ********
  // Properties
  // ********
  a_bus_released: assert property (@(posedge i_clock) disable iff (1'b0)
    i_rst |=> o_bus_hiz) else $error("bus port driven in reset");
  a_por_warn: assert property ($fell(i_rst) |=> !o_warn_oe_n)
    else $error("reset warning missing");
  a_fault_hold: assert property (!o_fault_oe_n && !clr && !mwr |=> !o_fault_oe_n)
    else $error("fault alert dropped");
  a_warn_hold: assert property (!o_warn_oe_n && !clr && !mwr |=> !o_warn_oe_n)
    else $error("warning alert dropped");
  a_clear_release: assert property (s_clear |=> o_fault_oe_n)
    else $error("fault alert kept after clear");
  a_supply_hiz: assert property (s_overvolt_run |=> o_state == 4'h2)
    else $error("no high impedance on supply fault");
  a_dc_hiz: assert property (run && i_chan_dc_offset[0] |=> o_chan_hiz[0])
    else $error("channel kept driving on offset");
  a_standby_idle: assert property (o_state == 4'h1 |-> !o_osc_run && &o_chan_hiz)
    else $error("standby with live outputs");
  a_mute_enter: assert property (o_state == 4'h8 && !i_mute_n && i_standby_n
    && !live |=> o_state == 4'h4) else $error("mute pin ignored");
  a_ramp_bound: assert property (ramp_q <= RAMP_CYCLES + 1)
    else $error("ramp too long");
endmodule

bind fws_supervisor fws_props #(.RAMP_CYCLES(RAMP_CYCLES)) u_fws_props (
  .i_clock(i_clock), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_bus_hiz(o_bus_hiz),
  .i_bat_undervoltage_event(i_bat_undervoltage_event),
  .i_stage_undervoltage_event(i_stage_undervoltage_event),
  .i_overvoltage_event(i_overvoltage_event), .i_clock_error(i_clock_error),
  .i_overtemp_shutdown(i_overtemp_shutdown), .i_chan_overcurrent(i_chan_overcurrent),
  .i_chan_dc_offset(i_chan_dc_offset), .i_mute_n(i_mute_n), .i_standby_n(i_standby_n),
  .o_fault_oe_n(o_fault_oe_n), .o_warn_oe_n(o_warn_oe_n), .o_state(o_state),
  .o_osc_run(o_osc_run), .o_ramp_down(o_ramp_down), .o_chan_hiz(o_chan_hiz));

// ===== test/fws_host_model.sv
/* Host controller model: register strobes, mute and standby pins.
   Assumes strobes are taken on the rising edge of i_clock. */
`timescale 1ns/10ps
module fws_host_model (
  input wire i_clock,
  input wire [7:0] i_reg_rdata,
  output reg o_reg_wr = 1'b0,
  output reg o_reg_rd = 1'b0,
  output reg [7:0] o_reg_addr = 8'h00,
  output reg [7:0] o_reg_wdata = 8'h00,
  output reg o_mute_n = 1'b1,
  output reg o_standby_n = 1'b0
);
  // Released lines show the inverse, so stale values never pass
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge i_clock);
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(negedge i_clock);
      o_reg_wr = 1'b0;
      o_reg_addr = ~a;
      o_reg_wdata = ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge i_clock);
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      @(negedge i_clock);
      o_reg_rd = 1'b0;
      o_reg_addr = ~a;
      @(negedge i_clock);
      d = i_reg_rdata;
    end
  endtask
  task clear;
    begin
      wr(8'h21, 8'h80);
    end
  endtask
  // mute and standby pins driven as given; supplies never removed here
  task pins(input m, input s);
    begin
      o_mute_n = m;
      o_standby_n = s;
    end
  endtask
endmodule

// ===== test/fws_supervisor_tb_top.sv
/* Bench for fws_supervisor driven by the host model.
   Assumes 100 MHz clock and a 16-cycle standby ramp. */
`timescale 1ns/10ps
module fws_supervisor_tb_top;
  localparam RAMP = 16;
  reg i_clock = 1'b0;
  reg i_rst = 1'b1;
  reg [4:0] flt = 5'h00;
  reg twarn = 1'b0;
  reg tick = 1'b0;
  reg [3:0] cotw = 4'h0;
  reg [3:0] ilim = 4'h0;
  reg [3:0] ocur = 4'h0;
  reg [3:0] dc = 4'h0;
  reg [3:0] fmod = 4'h0;
  integer mismatches = 0;
  integer compares = 0;
  integer i;
  integer n;
  wire wr, rd, mute_n, stby_n, hiz, f_out, f_oe_n, w_out, w_oe_n, osc, lvl, ramp;
  wire [7:0] addr, wdata, rdata;
  wire [3:0] state, chiz;
  wire [1:0] thr;
  // Open-drain alert pins with pull-ups
  wire fpin = f_oe_n ? 1'b1 : f_out;
  wire wpin = w_oe_n ? 1'b1 : w_out;
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  fws_supervisor #(.RAMP_CYCLES(RAMP)) u_fws_supervisor (
    .i_clock(i_clock), .i_rst(i_rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_bus_hiz(hiz),
    .i_bat_undervoltage_event(flt[0]), .i_stage_undervoltage_event(flt[1]),
    .i_overvoltage_event(flt[2]), .i_clock_error(flt[3]), .i_overtemp_shutdown(flt[4]),
    .i_overtemp_warning(twarn), .i_chan_overtemp_warning(cotw),
    .i_current_limit_warning(ilim), .i_chan_overcurrent(ocur), .i_chan_dc_offset(dc),
    .i_chan_full_mod(fmod), .i_pwm_tick(tick), .i_mute_n(mute_n), .i_standby_n(stby_n),
    .o_fault_out(f_out), .o_fault_oe_n(f_oe_n), .o_warn_out(w_out), .o_warn_oe_n(w_oe_n),
    .o_state(state), .o_osc_run(osc), .o_ramp_down(ramp), .o_chan_hiz(chiz),
    .o_overtemp_warning_threshold(thr), .o_current_limit_level(lvl));
  fws_host_model u_fws_host_model (
    .i_clock(i_clock), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_addr(addr), .o_reg_wdata(wdata), .o_mute_n(mute_n), .o_standby_n(stby_n));
  // ********
  // Helpers
  // ********
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task pin(input string nm, input e, input g);
    begin
      chk(nm, {7'h00, e}, {7'h00, g});
    end
  endtask
  task rchk(input [7:0] a, input [7:0] e);
    reg [7:0] d;
    begin
      u_fws_host_model.rd(a, d);
      chk($sformatf("reg %h", a), e, d);
    end
  endtask
  task cyc(input integer c);
    begin
      repeat (c) @(negedge i_clock);
    end
  endtask
  task clr;
    begin
      u_fws_host_model.clear;
      cyc(2);
    end
  endtask
  // ********
  // Scenarios
  // ********
  task t_por;
    begin
      i_rst = 1'b1;
      cyc(12);
      pin("bus_hiz", 1'b1, hiz);
      i_rst = 1'b0;
      cyc(2);
      pin("bus_hiz", 1'b0, hiz);
      pin("warn", 1'b0, wpin);
      rchk(8'h28, 8'h01);
      rchk(8'h23, 8'h14);
      rchk(8'h01, 8'h00);
      rchk(8'h29, 8'h00);
      rchk(8'h2a, 8'h00);
      rchk(8'h50, 8'h00);
      u_fws_host_model.wr(8'h01, 8'h70);
      cyc(1);
      chk("levels", 8'h07, {5'h00, thr, lvl});
      clr;
      pin("warn", 1'b1, wpin);
      rchk(8'h21, 8'h00);
      u_fws_host_model.pins(1'b1, 1'b1);
      cyc(4);
      chk("state", 8'h08, {4'h0, state});
      $display("por test end");
    end
  endtask
  task t_faults;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        flt = 5'h01 << i;
        cyc(2);
        pin("fault", 1'b0, fpin);
        if (i != 3) chk("state", 8'h02, {4'h0, state});
        flt = 5'h00;
        cyc(3);
        pin("fault", 1'b0, fpin);
        rchk(8'h26, 8'h01 << i);
        clr;
        pin("fault", 1'b1, fpin);
        rchk(8'h26, 8'h00);
        cyc(3);
        chk("state", 8'h08, {4'h0, state});
      end
      // Auto-recovery: play resumes while the fault pin stays latched
      u_fws_host_model.wr(8'h21, 8'h08);
      flt = 5'h10;
      cyc(2);
      flt = 5'h00;
      cyc(3);
      chk("state", 8'h08, {4'h0, state});
      pin("fault", 1'b0, fpin);
      clr;
      u_fws_host_model.wr(8'h29, 8'h01);
      flt = 5'h02;
      cyc(3);
      pin("fault", 1'b1, fpin);
      rchk(8'h26, 8'h02);
      flt = 5'h00;
      u_fws_host_model.wr(8'h29, 8'h00);
      clr;
      dc = 4'h1;
      ocur = 4'h8;
      cyc(2);
      chk("chan_hiz", 8'h09, {4'h0, chiz});
      pin("fault", 1'b0, fpin);
      dc = 4'h0;
      ocur = 4'h0;
      rchk(8'h27, 8'h18);
      clr;
      chk("chan_hiz", 8'h00, {4'h0, chiz});
      $display("fault test end");
    end
  endtask
  task t_warn;
    begin
      u_fws_host_model.wr(8'h2a, 8'h02);
      twarn = 1'b1;
      cyc(3);
      pin("warn", 1'b1, wpin);
      twarn = 1'b0;
      u_fws_host_model.wr(8'h2a, 8'h00);
      cotw = 4'h4;
      ilim = 4'h1;
      cyc(3);
      cotw = 4'h0;
      ilim = 4'h0;
      pin("warn", 1'b0, wpin);
      rchk(8'h28, 8'h4c);
      rchk(8'h25, 8'h01);
      pin("warn", 1'b0, wpin);
      clr;
      pin("warn", 1'b1, wpin);
      $display("warn test end");
    end
  endtask
  task t_clip;
    begin
      u_fws_host_model.wr(8'h23, 8'h03);
      fmod = 4'h4;
      for (i = 0; i < 3; i = i + 1) begin
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        cyc(3);
        pin("warn", i != 2, wpin);
      end
      fmod = 4'h0;
      rchk(8'h28, 8'h02);
      clr;
      rchk(8'h28, 8'h00);
      u_fws_host_model.wr(8'h22, 8'h01);
      fmod = 4'h1;
      rchk(8'h28, 8'h02);
      fmod = 4'h0;
      rchk(8'h28, 8'h00);
      u_fws_host_model.wr(8'h22, 8'h00);
      clr;
      $display("clip test end");
    end
  endtask
  task t_pins;
    begin
      u_fws_host_model.pins(1'b0, 1'b1);
      cyc(3);
      chk("state", 8'h04, {4'h0, state});
      u_fws_host_model.pins(1'b1, 1'b1);
      cyc(3);
      chk("state", 8'h08, {4'h0, state});
      u_fws_host_model.pins(1'b1, 1'b0);
      cyc(1);
      n = 1;
      pin("ramp_down", 1'b1, ramp);
      // Bounded wait for the ramp to finish
      while (state !== 4'h1 && n < 40) begin
        cyc(1);
        n = n + 1;
      end
      pin("ramp", 1'b1, n >= RAMP && n <= RAMP + 3);
      chk("idle", 8'h0f, {3'h0, osc, chiz});
      if (n >= 40) report_and_stop;
      $display("pin test end");
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  initial begin
    t_por;
    t_faults;
    t_warn;
    t_clip;
    t_pins;
    t_por;
    report_and_stop;
  end
endmodule
